// ==== src/sqd_flow.v ====
// Sequencer wait, loop and skip decoder with APB registers and program memory
//
// Behaviour
// [RL1] Opcode 0x80|W holds the PC until W timer overflows, then advances.
// [RL2] A wait field of zero waits for thirty-two overflows.
// [RL3] A finished timed wait sets the wait-done flag and moves on.
// [RL4] Opcode 0xB8 holds the PC until the next compare-one event.
// [RL5] Opcode 0xB9 holds the PC until the next compare-two event.
// [RL6] Opcode 0xBB records PC plus one as the loop start; the code records PC itself when PC equals plen_r minus one.
// [RL7] A label at the last memory location records its own address.
// [RL8] Only one loop start exists; each label overwrites it.
// [RL9] Repeat 0xA0|N|C jumps to the loop start when C xor N.
// [RL10] Repeat falls through when false or when no label was seen.
// [RL11] Negate inverts the chosen condition; codes select the radio, host and zero-flag sources.
// [RL12] Skip (bit 7 clear) advances PC by S plus one when true.
// [RL13] Skip with S zero and true condition re-executes itself.
// [RL14] A skip past the last instruction halts like a stop.
// [RL15] The reserved condition code reads false before negation.
// [RL16] The loop start is invalid after reset and after every restart.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sqd_flow_regs.vh"

module sqd_flow #(
    parameter PW    = 5,
    parameter DEPTH = 32
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // MAC timer events, one-cycle pulses
    input  wire        timer_overflow,
    input  wire        timer_compare_one,
    input  wire        timer_compare_two,
    // Radio status and register zero flags
    input  wire        clear_channel,
    input  wire        frame_sync,
    input  wire        signal_strength_valid,
    input  wire        x_zero,
    input  wire        y_zero,
    input  wire        z_zero,
    // Sequencer state and hand-off of other opcodes
    output reg  [PW-1:0] pc_r,
    output reg           busy_r,
    output reg           other_op_vld_r,
    output reg  [7:0]    other_op_r,
    // Interrupt
    output reg           irq_r
);

    // Sequencer states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_EXEC  = 3'h1;
    localparam [2:0] ST_WOVF  = 3'h2;
    localparam [2:0] ST_WCMP1 = 3'h3;
    localparam [2:0] ST_WCMP2 = 3'h4;

    reg [7:0]             prog_mem [0:DEPTH-1];
    reg [2:0]             state_r;
    reg [2:0]             state_nxt;
    reg [PW-1:0]          pc_nxt;
    reg [5:0]             left_r;
    reg [5:0]             left_nxt;
    reg [PW-1:0]          label_r;
    reg [PW-1:0]          label_nxt;
    reg                   lvld_r;
    reg                   lvld_nxt;
    reg [PW:0]            plen_r;
    reg                   hostc_r;
    reg [`SQD_IRQ_W-1:0]  istat_r;
    reg [`SQD_IRQ_W-1:0]  imask_r;
    reg                   go;
    reg                   wait_done;
    reg                   halt_ev;
    reg                   oop_vld_nxt;
    reg [PW:0]            tgt;
    reg [31:0]            rd_nxt;
    reg                   rd_err;

    wire [7:0]  instr = prog_mem[pc_r];
    wire        cond_true;
    wire [PW:0] pc_ext = {1'b0, pc_r};
    wire [PW:0] last_idx = plen_r - {{PW{1'b0}}, 1'b1};

    // APB phases: one wait state, writes land on the pready edge
    wire apb_acc   = psel & penable;
    wire wr_commit = apb_acc & pready & pwrite;
    wire prog_hit  = (paddr[11:8] == `SQD_PROG_PAGE);
    wire wr_ctrl   = wr_commit & (paddr == `SQD_OFF_CTRL);
    wire start_req = wr_ctrl & pwdata[`SQD_CTRL_START];
    wire halt_req  = wr_ctrl & pwdata[`SQD_CTRL_HALT];
    wire [PW-1:0] prog_idx = paddr[PW+1:2];

    // Condition evaluation shared by repeat and skip
    sqd_cond u_cond (
        .code                  (instr[`SQD_C_HI:0]),
        .negate                (instr[`SQD_NEG_BIT]),
        .clear_channel         (clear_channel),
        .frame_sync            (frame_sync),
        .host_condition_bit    (hostc_r),
        .x_zero                (x_zero),
        .y_zero                (y_zero),
        .z_zero                (z_zero),
        .signal_strength_valid (signal_strength_valid),
        .cond_true             (cond_true)
    );

    // Instruction decode and sequencing
    always @* begin
        state_nxt   = state_r;
        pc_nxt      = pc_r;
        left_nxt    = left_r;
        label_nxt   = label_r;
        lvld_nxt    = lvld_r;
        go          = 1'b0;
        wait_done   = 1'b0;
        halt_ev     = 1'b0;
        oop_vld_nxt = 1'b0;
        tgt         = pc_ext + {{PW{1'b0}}, 1'b1};
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_IDLE;
            end
            ST_EXEC: begin
                if ((instr & `SQD_WAIT_MASK) == `SQD_WAIT_VAL) begin
                    // Overflows seen in the issue cycle are not counted
                    state_nxt = ST_WOVF;
                    if (instr[`SQD_W_HI:0] == 5'h00) begin
                        left_nxt = `SQD_WAIT_ZERO_CNT;                // [RL2]
                    end else begin
                        left_nxt = {1'b0, instr[`SQD_W_HI:0]};        // [RL1]
                    end
                end else if (instr == `SQD_OP_WCMP1) begin
                    state_nxt = ST_WCMP1;                             // [RL4]
                end else if (instr == `SQD_OP_WCMP2) begin
                    state_nxt = ST_WCMP2;                             // [RL5]
                end else if (instr == `SQD_OP_LABEL) begin
                    // A new label simply replaces the old one
                    lvld_nxt = 1'b1;                                  // [RL8]
                    if (pc_ext == last_idx || pc_ext == DEPTH - 1) begin
                        label_nxt = pc_r;                             // [RL7]
                    end else begin
                        label_nxt = pc_r + {{(PW-1){1'b0}}, 1'b1};    // [RL6]
                    end
                    go = 1'b1;
                end else if ((instr & `SQD_RPT_MASK) == `SQD_RPT_VAL) begin
                    if (cond_true && lvld_r) begin
                        pc_nxt = label_r;                             // [RL9]
                    end else begin
                        go = 1'b1;                                    // [RL10]
                    end
                end else if (!instr[`SQD_SKIP_BIT]) begin
                    if (cond_true) begin
                        if (instr[`SQD_S_HI:`SQD_S_LO] == 3'h0) begin
                            pc_nxt = pc_r;                            // [RL13]
                        end else begin
                            tgt = pc_ext
                                + {{(PW-2){1'b0}}, instr[`SQD_S_HI:`SQD_S_LO]}
                                + {{PW{1'b0}}, 1'b1};                 // [RL12]
                            go  = 1'b1;
                        end
                    end else begin
                        go = 1'b1;
                    end
                end else begin
                    // Opcodes of other units pass on as a pulse
                    oop_vld_nxt = 1'b1;
                    go          = 1'b1;
                end
            end
            ST_WOVF: begin
                if (timer_overflow) begin
                    if (left_r == 6'h01) begin
                        wait_done = 1'b1;                             // [RL3]
                        go        = 1'b1;                             // [RL1]
                    end else begin
                        left_nxt = left_r - 6'h01;                    // [RL1]
                    end
                end
            end
            ST_WCMP1: begin
                go = timer_compare_one;                               // [RL4]
            end
            ST_WCMP2: begin
                go = timer_compare_two;                               // [RL5]
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Leaving the program by any path ends execution
        if (go) begin
            if (tgt >= plen_r) begin
                state_nxt = ST_IDLE;                                  // [RL14]
                halt_ev   = 1'b1;
            end else begin
                state_nxt = ST_EXEC;
                pc_nxt    = tgt[PW-1:0];
            end
        end
        // Software control wins over the running program
        if (start_req) begin
            state_nxt = (plen_r != {(PW+1){1'b0}}) ? ST_EXEC : ST_IDLE;
            pc_nxt    = {PW{1'b0}};
            lvld_nxt  = 1'b0;                                         // [RL16]
            halt_ev   = 1'b0;
            wait_done = 1'b0;
        end else if (halt_req) begin
            state_nxt = ST_IDLE;
        end
    end

    // Sequencer registers
    always @(posedge ref_clk) begin
        if (reset) begin
            state_r        <= ST_IDLE;
            pc_r           <= {PW{1'b0}};
            left_r         <= 6'h00;
            label_r        <= {PW{1'b0}};
            lvld_r         <= 1'b0;                                   // [RL16]
            busy_r         <= 1'b0;
            other_op_vld_r <= 1'b0;
            other_op_r     <= 8'h00;
        end else begin
            state_r        <= state_nxt;
            pc_r           <= pc_nxt;
            left_r         <= left_nxt;
            label_r        <= label_nxt;
            lvld_r         <= lvld_nxt;
            busy_r         <= (state_nxt != ST_IDLE);
            other_op_vld_r <= oop_vld_nxt;
            other_op_r     <= oop_vld_nxt ? instr : other_op_r;
        end
    end

    // Program memory, no reset needed; out-of-range words are refused, not aliased
    always @(posedge ref_clk) begin
        if (wr_commit && prog_hit && !rd_err) begin
            prog_mem[prog_idx] <= pwdata[7:0];
        end
    end

    // Read mux, unmapped addresses and out-of-range words give an error
    always @* begin
        rd_nxt = 32'h0000_0000;
        rd_err = 1'b0;
        if (prog_hit) begin
            if (paddr[7:2] < DEPTH && paddr[1:0] == 2'h0) begin
                rd_nxt = {24'h00_0000, prog_mem[prog_idx]};
            end else begin
                rd_err = 1'b1;
            end
        end else begin
            case (paddr)
                `SQD_OFF_CTRL:     rd_nxt = {29'h0000_0000, hostc_r, 2'h0};
                `SQD_OFF_STATUS:   rd_nxt = {8'h00, {(8-PW){1'b0}}, label_r,
                                             4'h0, lvld_r, state_r,
                                             {(8-PW){1'b0}}, pc_r};
                `SQD_OFF_PLEN:     rd_nxt = {{(31-PW){1'b0}}, plen_r};
                `SQD_OFF_IRQ_STAT: rd_nxt = {30'h0000_0000, istat_r};
                `SQD_OFF_IRQ_MASK: rd_nxt = {30'h0000_0000, imask_r};
                default:           rd_err = 1'b1;
            endcase
        end
    end

    // APB answer: pready follows one cycle into the access phase
    always @(posedge ref_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_acc & ~pready;
            pslverr <= apb_acc & ~pready & rd_err;
            if (apb_acc && !pready && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // Software registers
    always @(posedge ref_clk) begin
        if (reset) begin
            hostc_r <= 1'b0;
            plen_r  <= `SQD_RST_PLEN;
            imask_r <= `SQD_RST_MASK;
        end else begin
            if (wr_ctrl) begin
                hostc_r <= pwdata[`SQD_CTRL_HOSTC];
            end
            if (wr_commit && paddr == `SQD_OFF_PLEN) begin
                // Longer than the memory is clipped to the memory
                plen_r <= (pwdata > DEPTH) ? DEPTH[PW:0] : pwdata[PW:0];
            end
            if (wr_commit && paddr == `SQD_OFF_IRQ_MASK) begin
                imask_r <= pwdata[`SQD_IRQ_W-1:0];
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle survives the clear
    always @(posedge ref_clk) begin
        if (reset) begin
            istat_r <= {`SQD_IRQ_W{1'b0}};
            irq_r   <= 1'b0;
        end else begin
            istat_r[`SQD_IRQ_WAIT] <= wait_done | (istat_r[`SQD_IRQ_WAIT]   // [RL3]
                & ~(wr_commit && paddr == `SQD_OFF_IRQ_STAT
                    && pwdata[`SQD_IRQ_WAIT]));
            istat_r[`SQD_IRQ_HALT] <= halt_ev | (istat_r[`SQD_IRQ_HALT]
                & ~(wr_commit && paddr == `SQD_OFF_IRQ_STAT
                    && pwdata[`SQD_IRQ_HALT]));
            irq_r <= |(istat_r & imask_r);
        end
    end

endmodule // sqd_flow
`default_nettype wire

// ==== inc/sqd_flow_regs.vh ====
// Register map, opcodes and field constants of the sequencer flow decoder
`ifndef SQD_FLOW_REGS_VH
`define SQD_FLOW_REGS_VH

// Register byte offsets (paddr[11:0])
`define SQD_OFF_CTRL      12'h000
`define SQD_OFF_STATUS    12'h004
`define SQD_OFF_PLEN      12'h008
`define SQD_OFF_IRQ_STAT  12'h00C
`define SQD_OFF_IRQ_MASK  12'h010
// Program memory window: paddr[11:8] == 4'h1, word index in paddr[7:2]
`define SQD_PROG_PAGE     4'h1

// Control register bits
`define SQD_CTRL_START    0
`define SQD_CTRL_HALT     1
`define SQD_CTRL_HOSTC    2

// Interrupt status and mask bits
`define SQD_IRQ_WAIT      0
`define SQD_IRQ_HALT      1
`define SQD_IRQ_W         2

// Opcode patterns
`define SQD_WAIT_MASK     8'hE0
`define SQD_WAIT_VAL      8'h80
`define SQD_OP_WCMP1      8'hB8
`define SQD_OP_WCMP2      8'hB9
`define SQD_OP_LABEL      8'hBB
`define SQD_RPT_MASK      8'hF0
`define SQD_RPT_VAL       8'hA0
`define SQD_SKIP_BIT      7

// Instruction fields: wait count, skip count, negate and condition
`define SQD_W_HI          4
`define SQD_S_HI          6
`define SQD_S_LO          4
`define SQD_NEG_BIT       3
`define SQD_C_HI          2

// Overflow count used when the wait field is zero
`define SQD_WAIT_ZERO_CNT 6'h20

// Condition codes
`define SQD_C_CCA         3'h0
`define SQD_C_SYNC        3'h1
`define SQD_C_HOST        3'h2
`define SQD_C_RSVD        3'h3
`define SQD_C_XZ          3'h4
`define SQD_C_YZ          3'h5
`define SQD_C_ZZ          3'h6
`define SQD_C_RSSI        3'h7

// Reset values
`define SQD_RST_PLEN      6'h00
`define SQD_RST_MASK      2'h0

`endif

// ==== src/sqd_cond.v ====
// Condition selector with negate for repeat and skip instructions
`timescale 1ns/10ps
`default_nettype none
`include "sqd_flow_regs.vh"

module sqd_cond (
    // Condition field
    input  wire [2:0] code,
    input  wire       negate,
    // Condition sources
    input  wire       clear_channel,
    input  wire       frame_sync,
    input  wire       host_condition_bit,
    input  wire       x_zero,
    input  wire       y_zero,
    input  wire       z_zero,
    input  wire       signal_strength_valid,
    // Result
    output reg        cond_true
);

    reg sel;

    // Pick the source, then apply negate
    always @* begin
        case (code)
            `SQD_C_CCA:  sel = clear_channel;                  // [RL11]
            `SQD_C_SYNC: sel = frame_sync;                     // [RL11]
            `SQD_C_HOST: sel = host_condition_bit;             // [RL11]
            `SQD_C_XZ:   sel = x_zero;                         // [RL11]
            `SQD_C_YZ:   sel = y_zero;                         // [RL11]
            `SQD_C_ZZ:   sel = z_zero;                         // [RL11]
            `SQD_C_RSSI: sel = signal_strength_valid;          // [RL11]
            default:     sel = 1'b0;                           // Reserved code [RL15]
        endcase
        cond_true = sel ^ negate;                              // [RL11]
    end

endmodule // sqd_cond
`default_nettype wire

// ==== bench/sqd_flow_assertions.sv ====
// Bus and flow checker bound to the sequencer decoder
`timescale 1ns/10ps
`default_nettype none
`include "sqd_flow_regs.vh"
module sqd_flow_chk #(parameter PW = 5) (
    // Clock, reset and bus
    input wire logic          ref_clk,
    input wire logic          reset,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Sequencer state
    input wire logic [PW-1:0] pc_r,
    input wire logic          busy_r,
    input wire logic          other_op_vld_r,
    input wire logic [7:0]    other_op_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Bus phases
    sequence apb_setup; psel && !penable; endsequence
    sequence apb_wait; psel && penable && !pready; endsequence
    // Control write landing at this edge
    wire ctl_wr = psel && penable && pwrite && pready && paddr == `SQD_OFF_CTRL;
    wire any_wr = psel && penable && pwrite;
    ready_answer_a: assert property (apb_setup ##1 apb_wait |=> pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answer");
    idle_pc_a: assert property (!busy_r && !any_wr |=> $stable(pc_r))
        else $error("pc moved while stopped");
    start_pc_a: assert property (ctl_wr && pwdata[0] |=> pc_r == 0)
        else $error("start did not clear pc");
    halt_idle_a: assert property (ctl_wr && pwdata[1] && !pwdata[0] |=> !busy_r)
        else $error("halt left sequencer busy");
    status_pc_a: assert property (pready && !pwrite && paddr == `SQD_OFF_STATUS
        |-> prdata[PW-1:0] == $past(pc_r)) else $error("status pc mismatch");
    handoff_op_a: assert property (other_op_vld_r |-> other_op_r[7]
        && other_op_r[7:5] != 3'h4 && other_op_r[7:4] != 4'hA
        && other_op_r != `SQD_OP_WCMP1 && other_op_r != `SQD_OP_WCMP2
        && other_op_r != `SQD_OP_LABEL) else $error("own opcode handed off");
endmodule // sqd_flow_chk
bind sqd_flow sqd_flow_chk #(.PW(PW)) u_chk (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pc_r(pc_r), .busy_r(busy_r), .other_op_vld_r(other_op_vld_r),
    .other_op_r(other_op_r));
`default_nettype wire

// ==== bench/sqd_tmr_model.sv ====
// Timer event model: periodic overflows and compare pulses on demand
`timescale 1ns/10ps
`default_nettype none
module sqd_tmr (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Bench control, period zero keeps the timer quiet
    input  wire logic [3:0] ovf_per,
    input  wire logic       c1_go,
    input  wire logic       c2_go,
    // Timer events
    output var  logic       ovf,
    output var  logic       cmp1,
    output var  logic       cmp2
);
    logic [3:0] cnt_r;
    // One-cycle pulses, as the real timer gives them
    always @(posedge ref_clk) begin
        cmp1 <= c1_go && !reset;
        cmp2 <= c2_go && !reset;
        if (reset || ovf_per == 4'h0) begin
            cnt_r <= 4'h0;
            ovf <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == ovf_per - 4'h1) ? 4'h0 : cnt_r + 4'h1;
            ovf <= (cnt_r == ovf_per - 4'h1);
        end
    end
endmodule // sqd_tmr
`default_nettype wire

// ==== bench/sqd_flow_test.sv ====
// Self-checking bench for the sequencer flow decoder
`timescale 1ns/10ps
`default_nettype none
`include "sqd_flow_regs.vh"
module sqd_flow_test;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic cca, sync, xz, yz, zz, rssi, ovf, cmp1, cmp2, c1_go, c2_go;
    logic [3:0] ovf_per;
    logic [4:0] pc_r, c;
    logic busy_r, oth_v, irq_r;
    logic [7:0] oth, vec, oth_q;
    int n_errors, checks_done, n_ovf, n_cyc, k, p;
    sqd_flow #(.PW(5), .DEPTH(32)) u_dut (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_overflow(ovf), .timer_compare_one(cmp1), .timer_compare_two(cmp2),
        .clear_channel(cca), .frame_sync(sync), .signal_strength_valid(rssi),
        .x_zero(xz), .y_zero(yz), .z_zero(zz), .pc_r(pc_r), .busy_r(busy_r),
        .other_op_vld_r(oth_v), .other_op_r(oth), .irq_r(irq_r));
    sqd_tmr u_tmr (.ref_clk(ref_clk), .reset(reset), .ovf_per(ovf_per),
        .c1_go(c1_go), .c2_go(c2_go), .ovf(ovf), .cmp1(cmp1), .cmp2(cmp2));
    always #20 ref_clk = ~ref_clk;
    // Overflows seen while the first instruction still holds the pc; last handed-off opcode
    always @(posedge ref_clk) begin
        if (ovf && pc_r == 5'h0 && busy_r) n_ovf++;
        if (oth_v) oth_q <= oth;
        n_cyc++;
        if (n_cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Request held until pready is sampled high
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd_q = prdata;
        er_q = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic ld(input logic [5:0] i, input logic [7:0] b);
        wr({`SQD_PROG_PAGE, i, 2'b00}, {24'h0, b});
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(n, e, rd_q);
    endtask
    // Compare pulse well after the wait has issued
    task automatic ev(input logic two);
        tick(2);
        if (two) c2_go <= 1'b1;
        else c1_go <= 1'b1;
        tick(1);
        {c1_go, c2_go} <= 2'b00;
        tick(3);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ovf_per, c1_go, c2_go} = '0;
        {cca, sync, xz, yz, zz, rssi, ref_clk} = '0;
        reset = 1'b1;
        tick(5);
        reset <= 1'b0;
        tick(1);
        chk("pc busy irq", 32'h0, 32'({pc_r, busy_r, irq_r}));
        rdc("plen", `SQD_OFF_PLEN, 32'h0);
        rdc("mask", `SQD_OFF_IRQ_MASK, 32'h0);
        rdc("stat", `SQD_OFF_IRQ_STAT, 32'h0);
        xfer(12'h020, 1'b0, 32'h0);
        chk("slverr", 32'h1, 32'(er_q));
        $display("reset test done");
        // Timed waits of three and of thirty-two overflows
        for (k = 0; k < 2; k++) begin
            ld(6'h0, k ? 8'h80 : 8'h83);
            ld(6'h1, 8'h0B);
            wr(`SQD_OFF_PLEN, 32'h2);
            wr(`SQD_OFF_CTRL, 32'h1);
            n_ovf = 0;
            ovf_per <= 4'h4;
            tick(150);
            ovf_per <= 4'h0;
            chk("overflows", k ? 32'h20 : 32'h3, n_ovf);
            chk("pc busy", 32'h3, 32'({pc_r, busy_r}));
            rdc("stat", `SQD_OFF_IRQ_STAT, 32'h1);
            chk("irq", k, 32'(irq_r));
            wr(`SQD_OFF_IRQ_MASK, 32'h1);
            tick(2);
            chk("irq", 32'h1, 32'(irq_r));
            wr(`SQD_OFF_IRQ_STAT, 32'h1);
            tick(2);
            chk("irq", 32'h0, 32'(irq_r));
        end
        $display("wait test done");
        // Compare waits ignore the other event
        ld(6'h0, 8'hB8);
        ld(6'h1, 8'hB9);
        ld(6'h2, 8'h0B);
        wr(`SQD_OFF_PLEN, 32'h3);
        wr(`SQD_OFF_CTRL, 32'h1);
        for (k = 0; k < 4; k++) begin
            ev(!(k[0] ^ k[1]));
            chk("cmp pc", (k + 1) / 2, 32'(pc_r));
        end
        wr(`SQD_OFF_CTRL, 32'h2);
        tick(2);
        chk("halt busy", 32'h0, 32'(busy_r));
        $display("compare test done");
        // Two labels then a true repeat, later false
        ld(6'h0, 8'hBB);
        ld(6'h1, 8'hBB);
        ld(6'h2, 8'hA2);
        wr(`SQD_OFF_CTRL, 32'h5);
        tick(4);
        chk("rpt pc busy", 32'h5, 32'({pc_r, busy_r}));
        xfer(`SQD_OFF_STATUS, 1'b0, 32'h0);
        chk("label", 32'h5, 32'({rd_q[23:16], rd_q[11]}));
        wr(`SQD_OFF_CTRL, 32'h0);
        tick(3);
        chk("rpt end busy", 32'h0, 32'(busy_r));
        // Repeat before any label after a restart
        ld(6'h0, 8'hA2);
        ld(6'h1, 8'h0B);
        wr(`SQD_OFF_CTRL, 32'h5);
        tick(4);
        chk("no label pc", 32'h1, 32'(pc_r));
        xfer(`SQD_OFF_STATUS, 1'b0, 32'h0);
        chk("label valid", 32'h0, 32'(rd_q[11]));
        $display("loop test done");
        // Every condition code, both polarities, skip of one
        ld(6'h2, 8'h0B);
        for (p = 0; p < 2; p++) begin
            {cca, sync, xz, yz, zz, rssi} <= p ? 6'h1A : 6'h25;
            vec = p ? 8'h52 : 8'hA5;
            for (c = 5'h0; c < 5'h10; c++) begin
                ld(6'h0, {4'h1, c[3:0]});
                wr(`SQD_OFF_CTRL, p ? 32'h1 : 32'h5);
                tick(3);
                chk("skip pc", 32'(vec[c[2:0]] ^ c[3]) + 1, 32'(pc_r));
            end
        end
        $display("condition test done");
        // Label at the last location, reached by skips
        ld(6'h0, 8'h7B);
        ld(6'h8, 8'h7B);
        ld(6'h10, 8'h7B);
        ld(6'h18, 8'h6B);
        ld(6'h1F, 8'hBB);
        wr(`SQD_OFF_PLEN, 32'h20);
        wr(`SQD_OFF_CTRL, 32'h1);
        tick(8);
        chk("end busy", 32'h0, 32'(busy_r));
        xfer(`SQD_OFF_STATUS, 1'b0, 32'h0);
        chk("last label", 32'h3F, 32'({rd_q[23:16], rd_q[11]}));
        // Handed-off opcode, then a skip past the end
        ld(6'h0, 8'hD0);
        ld(6'h1, 8'h7B);
        wr(`SQD_OFF_PLEN, 32'h2);
        wr(`SQD_OFF_IRQ_STAT, 32'h3);
        wr(`SQD_OFF_IRQ_MASK, 32'h2);
        wr(`SQD_OFF_CTRL, 32'h1);
        tick(4);
        chk("overrun busy", 32'h0, 32'(busy_r));
        chk("halt irq", 32'h1, 32'(irq_r));
        chk("handoff op", 32'hD0, 32'(oth_q));
        rdc("stat", `SQD_OFF_IRQ_STAT, 32'h2);
        wr(`SQD_OFF_IRQ_STAT, 32'h2);
        tick(2);
        chk("irq", 32'h0, 32'(irq_r));
        $display("skip test done");
        give_verdict();
    end
endmodule // sqd_flow_test
`default_nettype wire
